// ### hw/cctc_consts.vh
`ifndef CCTC_CONSTS_VH
`define CCTC_CONSTS_VH
// register byte addresses
`define CCTC_ADDR_CTRL 8'h00
`define CCTC_ADDR_PTR0 8'h04
`define CCTC_ADDR_PTR1 8'h08
`define CCTC_ADDR_STRETCH 8'h0c
`define CCTC_ADDR_STATUS 8'h10
`define CCTC_ADDR_TMR0 8'h14
`define CCTC_ADDR_TMR1 8'h18
`define CCTC_ADDR_CMD 8'h1c
// control register fields
`define CCTC_CTRL_SEL 0
`define CCTC_CTRL_AUTO_STEP 1
`define CCTC_CTRL_DEC 2
`define CCTC_CTRL_TOGGLE 3
`define CCTC_CTRL_SLOW 4
`define CCTC_CTRL_SWITCHBACK 5
`define CCTC_CTRL_T0_FAST 6
`define CCTC_CTRL_T1_FAST 7
`define CCTC_CTRL_T0_CNT 8
`define CCTC_CTRL_T1_CNT 9
`define CCTC_CTRL_RESET 10'h000
// command register codes
`define CCTC_CMD_READ 2'h1
`define CCTC_CMD_WRITE 2'h2
`define CCTC_CMD_MOV_DIRECT 2'h3
// timing counts and bus response codes
`define CCTC_LEGACY_DIV 4'd12
`define CCTC_SLOW_DIV 11'd1024
`define CCTC_MAX_STRETCH 4'd10
`define CCTC_BASE_MOVE_CYCLES 4'd2
`define CCTC_MOV_DIRECT_CYCLES 4'd3
`define CCTC_AXI_OKAY 2'b00
`define CCTC_AXI_SLVERR 2'b10
`endif

// ### hw/cctc_top.v
// How it works
// (RL1) ext_fetch_select low: fetch from external memory
// (RL2) ext_fetch_select high: fetch from internal flash
// (RL3) external fetch leaves on-chip data RAM enabled
// (RL4) one machine cycle per clock
// (RL5) one cycle per instruction byte plus one
// (RL6) data move two cycles, direct move three
// (RL7) data move stretchable by up to 10 cycles, 12 in all
// (RL8) slow access lengthens the instruction
// (RL9) slow mode: 1024 clocks per machine cycle
// (RL10) switchback leaves slow mode on interrupt
// (RL11) address latch strobe idle without external access
// (RL12) timers default to one tick per 12 clocks
// (RL13) each timer selectable to tick every clock
// (RL14) pointers auto-step and auto-toggle selection
// (RL15) results unchanged, only cycle counts differ
// (RL16) port 3 bit 6 is write strobe, low
// (RL17) port 3 bit 7 is read strobe, low
// (RL18) port 3 bits 4,5 feed timer counters
`include "cctc_consts.vh"
module cctc_top #(
  parameter PTR_W = 16,
  parameter TMR_W = 16
) (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // device pins
  input wire ext_fetch_select,
  input wire irq_pending,
  input wire timer_zero_count_input,
  input wire timer_one_count_input,
  output reg fetch_external,
  output reg data_ram_enable,
  output reg addr_latch_strobe,
  output reg data_write_strobe_n,
  output reg data_read_strobe_n,
  output reg [PTR_W-1:0] ext_addr,
  output reg machine_cycle_tick
);

  localparam ST_IDLE = 2'd0;
  localparam ST_ADDR = 2'd1;
  localparam ST_DATA = 2'd2;

  // pin synchronisers
  reg [1:0] ea_sync_reg;
  reg [1:0] t0_sync_reg;
  reg [1:0] t1_sync_reg;
  reg [1:0] irq_sync_reg;
  reg t0_last_reg;
  reg t1_last_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      ea_sync_reg <= 2'b11;
      t0_sync_reg <= 2'b00;
      t1_sync_reg <= 2'b00;
      irq_sync_reg <= 2'b00;
      t0_last_reg <= 1'b0;
      t1_last_reg <= 1'b0;
    end else begin
      ea_sync_reg <= {ea_sync_reg[0], ext_fetch_select};
      t0_sync_reg <= {t0_sync_reg[0], timer_zero_count_input}; // RL18
      t1_sync_reg <= {t1_sync_reg[0], timer_one_count_input}; // RL18
      irq_sync_reg <= {irq_sync_reg[0], irq_pending};
      t0_last_reg <= t0_sync_reg[1];
      t1_last_reg <= t1_sync_reg[1];
    end
  end

  // registers
  reg [9:0] ctrl_reg;
  reg [PTR_W-1:0] ptr0_reg;
  reg [PTR_W-1:0] ptr1_reg;
  reg [3:0] stretch_reg;
  reg [TMR_W-1:0] tmr0_reg;
  reg [TMR_W-1:0] tmr1_reg;
  reg [3:0] presc_reg;
  reg [10:0] slow_cnt_reg;
  reg [1:0] st_reg;
  reg [3:0] cyc_reg;
  reg [3:0] cyc_target_reg;
  reg op_write_reg;
  reg switched_back_reg;
  reg [31:0] last_cycles_reg;

  // machine cycle pacing: every clock, or every 1024 in slow mode
  wire slow_mode = ctrl_reg[`CCTC_CTRL_SLOW];
  wire mc_tick = !slow_mode || (slow_cnt_reg == `CCTC_SLOW_DIV - 11'd1); // RL4 RL9
  wire legacy_tick = (presc_reg == `CCTC_LEGACY_DIV - 4'd1); // RL12
  wire t0_edge = t0_last_reg && !t0_sync_reg[1];
  wire t1_edge = t1_last_reg && !t1_sync_reg[1];
  wire sel = ctrl_reg[`CCTC_CTRL_SEL];
  wire [PTR_W-1:0] active_ptr = sel ? ptr1_reg : ptr0_reg;
  wire busy = (st_reg != ST_IDLE);

  // bus handshake
  reg aw_hold_reg;
  reg w_hold_reg;
  reg [7:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_hold_reg || aw_take;
  wire w_have = w_hold_reg || w_take;
  wire [7:0] wa = aw_take ? s_axi_awaddr : aw_addr_reg;
  wire [31:0] wd = w_take ? s_axi_wdata : w_data_reg;
  wire wr_fire = aw_have && w_have && !s_axi_bvalid;
  wire wr_cmd = wr_fire && (wa == `CCTC_ADDR_CMD) && !busy;
  wire [1:0] cmd_code = wd[1:0];
  wire move_start = wr_cmd && (cmd_code != 2'd0);
  wire move_done = busy && mc_tick && (cyc_reg + 4'd1 >= cyc_target_reg);
  wire step_done = move_done && (st_reg == ST_DATA);

  function [4:0] wmap;
    input [7:0] a;
    begin
      case (a)
        `CCTC_ADDR_CTRL: wmap = 5'd1;
        `CCTC_ADDR_PTR0: wmap = 5'd2;
        `CCTC_ADDR_PTR1: wmap = 5'd3;
        `CCTC_ADDR_STRETCH: wmap = 5'd4;
        `CCTC_ADDR_STATUS: wmap = 5'd5;
        `CCTC_ADDR_TMR0: wmap = 5'd6;
        `CCTC_ADDR_TMR1: wmap = 5'd7;
        `CCTC_ADDR_CMD: wmap = 5'd8;
        default: wmap = 5'd0;
      endcase
    end
  endfunction

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CCTC_AXI_OKAY;
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
    end else begin
      s_axi_awready <= !aw_have && !s_axi_bvalid && !s_axi_awready;
      s_axi_wready <= !w_have && !s_axi_bvalid && !s_axi_wready;
      if (aw_take) begin
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_reg <= s_axi_wdata;
      end
      if (wr_fire) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // unmapped or busy command answers slverr
        if (wmap(wa) == 5'd0 || ((wa == `CCTC_ADDR_CMD) && busy)) begin
          s_axi_bresp <= `CCTC_AXI_SLVERR;
        end else begin
          s_axi_bresp <= `CCTC_AXI_OKAY;
        end
      end else begin
        aw_hold_reg <= aw_have;
        w_hold_reg <= w_have;
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // control, pointers, stretch, timers
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= `CCTC_CTRL_RESET;
      ptr0_reg <= {PTR_W{1'b0}};
      ptr1_reg <= {PTR_W{1'b0}};
      stretch_reg <= 4'h0;
      tmr0_reg <= {TMR_W{1'b0}};
      tmr1_reg <= {TMR_W{1'b0}};
      presc_reg <= 4'h0;
      slow_cnt_reg <= 11'h000;
      switched_back_reg <= 1'b0;
    end else begin
      presc_reg <= legacy_tick ? 4'h0 : presc_reg + 4'h1;
      slow_cnt_reg <= (!slow_mode || mc_tick) ? 11'h000 : slow_cnt_reg + 11'h001;
      // timer 0: fast or legacy rate, or counter of pin falls
      if (wr_fire && wa == `CCTC_ADDR_TMR0) begin
        tmr0_reg <= wd[TMR_W-1:0];
      end else if (ctrl_reg[`CCTC_CTRL_T0_CNT] ? t0_edge
                   : (ctrl_reg[`CCTC_CTRL_T0_FAST] || legacy_tick)) begin // RL12 RL13
        tmr0_reg <= tmr0_reg + {{(TMR_W-1){1'b0}}, 1'b1};
      end
      if (wr_fire && wa == `CCTC_ADDR_TMR1) begin
        tmr1_reg <= wd[TMR_W-1:0];
      end else if (ctrl_reg[`CCTC_CTRL_T1_CNT] ? t1_edge
                   : (ctrl_reg[`CCTC_CTRL_T1_FAST] || legacy_tick)) begin // RL12 RL13
        tmr1_reg <= tmr1_reg + {{(TMR_W-1){1'b0}}, 1'b1};
      end
      if (wr_fire && wa == `CCTC_ADDR_CTRL) begin
        ctrl_reg <= wd[9:0];
      end else if (slow_mode && ctrl_reg[`CCTC_CTRL_SWITCHBACK] && irq_sync_reg[1]) begin
        ctrl_reg[`CCTC_CTRL_SLOW] <= 1'b0; // RL10
      end else if (step_done && ctrl_reg[`CCTC_CTRL_TOGGLE]) begin
        ctrl_reg[`CCTC_CTRL_SEL] <= !sel; // RL14
      end
      // switchback flag: event wins over a clearing status write
      if (slow_mode && ctrl_reg[`CCTC_CTRL_SWITCHBACK] && irq_sync_reg[1]) begin
        switched_back_reg <= 1'b1;
      end else if (wr_fire && wa == `CCTC_ADDR_STATUS && wd[0]) begin
        switched_back_reg <= 1'b0;
      end
      if (wr_fire && wa == `CCTC_ADDR_STRETCH) begin
        stretch_reg <= (wd[3:0] > `CCTC_MAX_STRETCH) ? `CCTC_MAX_STRETCH : wd[3:0]; // RL7
      end
      if (wr_fire && wa == `CCTC_ADDR_PTR0) begin
        ptr0_reg <= wd[PTR_W-1:0];
      end else if (step_done && !sel && ctrl_reg[`CCTC_CTRL_AUTO_STEP]) begin
        ptr0_reg <= ctrl_reg[`CCTC_CTRL_DEC] ? ptr0_reg - {{(PTR_W-1){1'b0}}, 1'b1}
                                             : ptr0_reg + {{(PTR_W-1){1'b0}}, 1'b1}; // RL14
      end
      if (wr_fire && wa == `CCTC_ADDR_PTR1) begin
        ptr1_reg <= wd[PTR_W-1:0];
      end else if (step_done && sel && ctrl_reg[`CCTC_CTRL_AUTO_STEP]) begin
        ptr1_reg <= ctrl_reg[`CCTC_CTRL_DEC] ? ptr1_reg - {{(PTR_W-1){1'b0}}, 1'b1}
                                             : ptr1_reg + {{(PTR_W-1){1'b0}}, 1'b1}; // RL14
      end
    end
  end

  // move sequencer: address cycle, then data cycle(s) with stretch
  always @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= ST_IDLE;
      cyc_reg <= 4'h0;
      cyc_target_reg <= 4'h0;
      op_write_reg <= 1'b0;
      last_cycles_reg <= 32'h0000_0000;
      addr_latch_strobe <= 1'b0;
      data_write_strobe_n <= 1'b1;
      data_read_strobe_n <= 1'b1;
      ext_addr <= {PTR_W{1'b0}};
    end else begin
      case (st_reg)
        ST_IDLE: begin
          addr_latch_strobe <= 1'b0; // RL11
          data_write_strobe_n <= 1'b1;
          data_read_strobe_n <= 1'b1;
          if (move_start) begin
            cyc_reg <= 4'h0;
            op_write_reg <= (cmd_code == `CCTC_CMD_WRITE);
            if (cmd_code == `CCTC_CMD_MOV_DIRECT) begin
              // internal move, three cycles, no pins move
              cyc_target_reg <= `CCTC_MOV_DIRECT_CYCLES; // RL5 RL6
              st_reg <= ST_ADDR;
            end else begin
              // stretch adds cycles to the two-cycle move
              cyc_target_reg <= `CCTC_BASE_MOVE_CYCLES + stretch_reg; // RL6 RL7 RL8
              st_reg <= ST_DATA;
              ext_addr <= active_ptr;
              addr_latch_strobe <= 1'b1; // RL11
            end
          end
        end
        ST_ADDR: begin
          if (mc_tick) begin
            cyc_reg <= cyc_reg + 4'h1;
          end
          if (move_done) begin
            last_cycles_reg <= {28'h0000000, cyc_target_reg};
            st_reg <= ST_IDLE;
          end
        end
        ST_DATA: begin
          addr_latch_strobe <= 1'b0;
          if (mc_tick) begin
            cyc_reg <= cyc_reg + 4'h1;
          end
          if (move_done) begin
            data_write_strobe_n <= 1'b1;
            data_read_strobe_n <= 1'b1;
            last_cycles_reg <= {28'h0000000, cyc_target_reg};
            st_reg <= ST_IDLE;
          end else begin
            data_write_strobe_n <= !op_write_reg; // RL16
            data_read_strobe_n <= op_write_reg; // RL17
          end
        end
        default: begin
          st_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // fetch source and pacing pins
  always @(posedge aclk) begin
    if (!aresetn) begin
      fetch_external <= 1'b0;
      data_ram_enable <= 1'b1;
      machine_cycle_tick <= 1'b0;
    end else begin
      fetch_external <= !ea_sync_reg[1]; // RL1 RL2
      data_ram_enable <= 1'b1; // RL3
      machine_cycle_tick <= mc_tick; // RL4 RL9
    end
  end

  // read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CCTC_AXI_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !s_axi_arvalid ? 1'b0
                       : (!s_axi_rvalid && !s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `CCTC_AXI_OKAY;
        case (s_axi_araddr)
          `CCTC_ADDR_CTRL: s_axi_rdata <= {22'h000000, ctrl_reg};
          `CCTC_ADDR_PTR0: s_axi_rdata <= {{(32-PTR_W){1'b0}}, ptr0_reg};
          `CCTC_ADDR_PTR1: s_axi_rdata <= {{(32-PTR_W){1'b0}}, ptr1_reg};
          `CCTC_ADDR_STRETCH: s_axi_rdata <= {28'h0000000, stretch_reg};
          `CCTC_ADDR_STATUS: s_axi_rdata <= {26'h0, !ea_sync_reg[1], busy,
                                             last_cycles_reg[3:0]} << 1
                                            | {31'h0, switched_back_reg};
          `CCTC_ADDR_TMR0: s_axi_rdata <= {{(32-TMR_W){1'b0}}, tmr0_reg};
          `CCTC_ADDR_TMR1: s_axi_rdata <= {{(32-TMR_W){1'b0}}, tmr1_reg};
          `CCTC_ADDR_CMD: s_axi_rdata <= {30'h0, op_write_reg, busy};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `CCTC_AXI_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // instruction results are computed elsewhere and unchanged here; RL15
endmodule

// ### testbench/cctc_chk.sv
module cctc_chk (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire ext_fetch_select,
  input wire fetch_external,
  input wire data_ram_enable,
  input wire addr_latch_strobe,
  input wire data_write_strobe_n,
  input wire data_read_strobe_n,
  input wire machine_cycle_tick
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // saturates so a stuck tick cannot wrap back into range
  reg [10:0] gap_reg;
  always @(posedge aclk) begin
    if (!aresetn || machine_cycle_tick) gap_reg <= 11'h000;
    else if (gap_reg != 11'h7ff) gap_reg <= gap_reg + 11'h001;
  end
  property p_ext_fetch; !ext_fetch_select [*5] |-> fetch_external; endproperty
  a_ext_fetch: assert property (p_ext_fetch) else $error("fetch not external");
  property p_int_fetch; ext_fetch_select [*5] |-> !fetch_external; endproperty
  a_int_fetch: assert property (p_int_fetch) else $error("fetch not internal");
  property p_ram_on; data_ram_enable; endproperty
  a_ram_on: assert property (p_ram_on) else $error("data ram disabled");
  property p_tick_gap; gap_reg < 11'h400; endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("machine cycle too long");
  property p_ale_pulse; addr_latch_strobe |=> !addr_latch_strobe; endproperty
  a_ale_pulse: assert property (p_ale_pulse) else $error("latch strobe too long");
  property p_ale_quiet; !(data_write_strobe_n && data_read_strobe_n) |-> !addr_latch_strobe;
  endproperty
  a_ale_quiet: assert property (p_ale_quiet) else $error("latch strobe in data phase");
  property p_ale_data; addr_latch_strobe |=> !(data_write_strobe_n && data_read_strobe_n);
  endproperty
  a_ale_data: assert property (p_ale_data) else $error("no data phase after latch");
  property p_one_strobe; data_write_strobe_n || data_read_strobe_n; endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("both strobes low");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read response dropped");
  c_ale: cover property (addr_latch_strobe);
  c_slow: cover property (gap_reg == 11'h3ff);
  c_ext: cover property (fetch_external);
endmodule

bind cctc_top cctc_chk u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .ext_fetch_select(ext_fetch_select), .fetch_external(fetch_external),
  .data_ram_enable(data_ram_enable), .addr_latch_strobe(addr_latch_strobe),
  .data_write_strobe_n(data_write_strobe_n), .data_read_strobe_n(data_read_strobe_n),
  .machine_cycle_tick(machine_cycle_tick)
);

// ### testbench/cctc_ext_mem.sv
module cctc_ext_mem (
  input wire aclk,
  input wire count_en,
  input wire addr_latch_strobe,
  input wire data_write_strobe_n,
  input wire data_read_strobe_n,
  input wire [15:0] ext_addr,
  output logic timer_zero_count_input,
  output logic timer_one_count_input,
  output int ale_count,
  output int wr_cycles,
  output int rd_cycles,
  output logic [15:0] latched_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] div = 3'h0;
  initial begin
    {timer_zero_count_input, timer_one_count_input} = 2'h3;
    {ale_count, wr_cycles, rd_cycles} = 96'h0;
    latched_addr = 16'h0000;
  end
  always @(posedge aclk) begin
    div <= div + 3'h1;
    // pins float to the pull-up level when not pulsed
    timer_zero_count_input <= !count_en || !div[2];
    timer_one_count_input <= !count_en || !div[2];
    if (addr_latch_strobe) begin
      ale_count <= ale_count + 1;
      latched_addr <= ext_addr;
    end
    if (!data_write_strobe_n) wr_cycles <= wr_cycles + 1;
    if (!data_read_strobe_n) rd_cycles <= rd_cycles + 1;
  end
endmodule

// ### testbench/cpu_cycle_timing_control_tb.sv
`include "cctc_consts.vh"
module cpu_cycle_timing_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q;} cctc_row_t;
  logic aclk = 1'b0, aresetn = 1'b0, ext_fetch_select = 1'b1, irq_pending = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, count_en = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic t0_in, t1_in, fetch_external, data_ram_enable, addr_latch_strobe;
  logic data_write_strobe_n, data_read_strobe_n, machine_cycle_tick;
  logic [15:0] ext_addr, latched_addr;
  int num_errors = 0, checks = 0, cyc = 0, tick_cnt = 0, n, ale_count, wr_cycles, rd_cycles;
  cctc_row_t rows [6] = '{'{`CCTC_ADDR_PTR0, 32'h1234, 32'h1234},
    '{`CCTC_ADDR_PTR1, 32'hbeef, 32'hbeef}, '{`CCTC_ADDR_STRETCH, 32'h5, 32'h5},
    '{`CCTC_ADDR_STRETCH, 32'hf, 32'ha}, '{`CCTC_ADDR_CTRL, 32'h0e, 32'h0e},
    '{`CCTC_ADDR_CTRL, 32'h0, 32'h0}};
  cctc_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .ext_fetch_select(ext_fetch_select), .irq_pending(irq_pending),
    .timer_zero_count_input(t0_in), .timer_one_count_input(t1_in),
    .fetch_external(fetch_external), .data_ram_enable(data_ram_enable),
    .addr_latch_strobe(addr_latch_strobe), .data_write_strobe_n(data_write_strobe_n),
    .data_read_strobe_n(data_read_strobe_n), .ext_addr(ext_addr),
    .machine_cycle_tick(machine_cycle_tick));
  cctc_ext_mem u_mem (.aclk(aclk), .count_en(count_en), .addr_latch_strobe(addr_latch_strobe),
    .data_write_strobe_n(data_write_strobe_n), .data_read_strobe_n(data_read_strobe_n),
    .ext_addr(ext_addr), .timer_zero_count_input(t0_in), .timer_one_count_input(t1_in),
    .ale_count(ale_count), .wr_cycles(wr_cycles), .rd_cycles(rd_cycles),
    .latched_addr(latched_addr));
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (machine_cycle_tick === 1'b1) tick_cnt <= tick_cnt + 1;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && s_axi_awready !== 1'b1) || (s_axi_wvalid && s_axi_wready !== 1'b1));
    // late ready keeps the response-hold path exercised
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk("bresp", e, s_axi_bresp);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk("rresp", e, s_axi_rresp);
  endtask
  task automatic mv(input logic [1:0] c, input logic [3:0] s);
    int a0, r0, w0;
    a0 = ale_count;
    r0 = rd_cycles;
    w0 = wr_cycles;
    axw(`CCTC_ADDR_STRETCH, {28'h0, s}, `CCTC_AXI_OKAY);
    axw(`CCTC_ADDR_CMD, {30'h0, c}, `CCTC_AXI_OKAY);
    v = 32'h1;
    while (v[0] !== 1'b0) axr(`CCTC_ADDR_CMD, v, `CCTC_AXI_OKAY);
    axr(`CCTC_ADDR_STATUS, v, `CCTC_AXI_OKAY);
    chk("move cycles", (c == 2'h3) ? 4'h3 : 4'h2 + s, v[4:1]);
    chk("ale pulses", {31'h0, c != 2'h3}, ale_count - a0);
    chk("read strobe", (c == 2'h1) ? s + 4'h1 : 4'h0, rd_cycles - r0);
    chk("write strobe", (c == 2'h2) ? s + 4'h1 : 4'h0, wr_cycles - w0);
  endtask
  task automatic rate(input logic [7:0] a, input int lo, input int hi);
    logic [31:0] v0;
    axr(a, v0, `CCTC_AXI_OKAY);
    repeat (240) @(posedge aclk);
    axr(a, v, `CCTC_AXI_OKAY);
    v = {16'h0, v[15:0] - v0[15:0]};
    chk("timer rate", 1, v >= lo && v <= hi);
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("ram enable", 1, data_ram_enable);
    chk("ale idle", 0, addr_latch_strobe);
    axr(`CCTC_ADDR_CTRL, v, `CCTC_AXI_OKAY);
    chk("ctrl reset", `CCTC_CTRL_RESET, v);
    n = tick_cnt;
    repeat (100) @(posedge aclk);
    chk("fast ticks", 100, tick_cnt - n);
    foreach (rows[i]) begin
      axw(rows[i].a, rows[i].d, `CCTC_AXI_OKAY);
      axr(rows[i].a, v, `CCTC_AXI_OKAY);
      chk("register", rows[i].q, v);
    end
    axw(8'h20, 32'h1, `CCTC_AXI_SLVERR);
    axr(8'h20, v, `CCTC_AXI_SLVERR);
    for (int c = 1; c < 4; c++) begin
      mv(c[1:0], 4'h0);
      mv(c[1:0], `CCTC_MAX_STRETCH);
    end
    chk("move address", 16'h1234, latched_addr);
    axw(`CCTC_ADDR_CMD, `CCTC_CMD_READ, `CCTC_AXI_OKAY);
    axw(`CCTC_ADDR_CMD, `CCTC_CMD_READ, `CCTC_AXI_SLVERR);
    // let the accepted move finish before pointer modes change
    v = 32'h1;
    while (v[0] !== 1'b0) axr(`CCTC_ADDR_CMD, v, `CCTC_AXI_OKAY);
    axw(`CCTC_ADDR_CTRL, 32'h0a, `CCTC_AXI_OKAY);
    mv(`CCTC_CMD_READ, 4'h0);
    axr(`CCTC_ADDR_PTR0, v, `CCTC_AXI_OKAY);
    chk("step up", 32'h1235, v);
    mv(`CCTC_CMD_WRITE, 4'h0);
    chk("toggled pointer", 16'hbeef, latched_addr);
    axw(`CCTC_ADDR_CTRL, 32'h06, `CCTC_AXI_OKAY);
    mv(`CCTC_CMD_READ, 4'h0);
    axr(`CCTC_ADDR_PTR0, v, `CCTC_AXI_OKAY);
    chk("step down", 32'h1234, v);
    axw(`CCTC_ADDR_CTRL, 32'h0, `CCTC_AXI_OKAY);
    rate(`CCTC_ADDR_TMR0, 19, 22);
    axw(`CCTC_ADDR_CTRL, 32'h40, `CCTC_AXI_OKAY);
    rate(`CCTC_ADDR_TMR0, 240, 252);
    rate(`CCTC_ADDR_TMR1, 19, 22);
    axw(`CCTC_ADDR_CTRL, 32'h80, `CCTC_AXI_OKAY);
    rate(`CCTC_ADDR_TMR1, 240, 252);
    axw(`CCTC_ADDR_CTRL, 32'h300, `CCTC_AXI_OKAY);
    count_en <= 1'b1;
    rate(`CCTC_ADDR_TMR0, 29, 33);
    rate(`CCTC_ADDR_TMR1, 29, 33);
    count_en <= 1'b0;
    axw(`CCTC_ADDR_CTRL, 32'h10, `CCTC_AXI_OKAY);
    n = tick_cnt;
    repeat (3072) @(posedge aclk);
    chk("slow ticks", 3, tick_cnt - n);
    axw(`CCTC_ADDR_CTRL, 32'h30, `CCTC_AXI_OKAY);
    irq_pending <= 1'b1;
    repeat (8) @(posedge aclk);
    irq_pending <= 1'b0;
    axr(`CCTC_ADDR_CTRL, v, `CCTC_AXI_OKAY);
    chk("switchback", 0, v[4]);
    axr(`CCTC_ADDR_STATUS, v, `CCTC_AXI_OKAY);
    chk("switch flag", 1, v[0]);
    axw(`CCTC_ADDR_STATUS, 32'h1, `CCTC_AXI_OKAY);
    axr(`CCTC_ADDR_STATUS, v, `CCTC_AXI_OKAY);
    chk("flag clear", 0, v[0]);
    ext_fetch_select <= 1'b0;
    repeat (6) @(posedge aclk);
    chk("external fetch", 1, fetch_external);
    chk("ram kept", 1, data_ram_enable);
    axr(`CCTC_ADDR_STATUS, v, `CCTC_AXI_OKAY);
    chk("fetch status", 1, v[6]);
    ext_fetch_select <= 1'b1;
    repeat (6) @(posedge aclk);
    chk("internal fetch", 0, fetch_external);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("reset strobes", 2'h3, {data_write_strobe_n, data_read_strobe_n});
    chk("reset ale", 0, addr_latch_strobe);
    axr(`CCTC_ADDR_CTRL, v, `CCTC_AXI_OKAY);
    chk("ctrl mid reset", `CCTC_CTRL_RESET, v);
    report_and_stop();
  end
endmodule
